// ---- assr_top.sv ----
// Automatic multi-step speed sequencer with an AXI4-Lite register slave.
//
// How it works
// - Basic sequence: jog, speed one, two, three, stop, each with own period.
// - Reversing sequence flips direction after step five, runs six to ten, restarts.
// - Mode four runs steps one to four like mode two.
// - Mode four commands main speed in step five, then restarts at step one.
// - Mode five runs steps one-four and six-nine like mode three.
// - Mode five commands main speed in steps five and ten.
// - Mode five restarts at step one after step ten, repeating forever.
// - Mode six runs like mode four, then loops steps two to five.
// - Assignable digital outputs indicate auto-run state while running.
`default_nettype none
module assr_top #(
    parameter int TICK_CYCLES = assr_pkg::ASSR_TICK_CYCLES,
    parameter int PER_W       = assr_pkg::ASSR_PER_W,
    parameter int DO_N        = assr_pkg::ASSR_DO_N
) (
    // Clock and reset
    input  wire logic                 aclk,
    input  wire logic                 aresetn,
    // AXI4-Lite write address and data
    input  wire logic [7:0]           s_axi_awaddr,
    input  wire logic                 s_axi_awvalid,
    output var  logic                 s_axi_awready,
    input  wire logic [31:0]          s_axi_wdata,
    input  wire logic [3:0]           s_axi_wstrb,
    input  wire logic                 s_axi_wvalid,
    output var  logic                 s_axi_wready,
    // AXI4-Lite write response
    output var  logic [1:0]           s_axi_bresp,
    output var  logic                 s_axi_bvalid,
    input  wire logic                 s_axi_bready,
    // AXI4-Lite read
    input  wire logic [7:0]           s_axi_araddr,
    input  wire logic                 s_axi_arvalid,
    output var  logic                 s_axi_arready,
    output var  logic [31:0]          s_axi_rdata,
    output var  logic [1:0]           s_axi_rresp,
    output var  logic                 s_axi_rvalid,
    input  wire logic                 s_axi_rready,
    // Speed command to the drive
    output var  logic [2:0]           speed_cmd,
    output var  logic                 reverse_dir,
    output var  logic [3:0]           step_num,
    // Auto-run indication
    output var  logic [DO_N-1:0]      digital_output_n
);
    import assr_pkg::*;

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    logic             run_r, run_nxt;
    logic [2:0]       mode_r, mode_nxt;
    logic [PER_W-1:0] per_r [5];
    logic [PER_W-1:0] per_nxt [5];
    logic [DO_N-1:0]  do_sel_r, do_sel_nxt;
    logic             aw_hold_r, aw_hold_nxt, w_hold_r, w_hold_nxt;
    logic [7:0]       aw_addr_r, aw_addr_nxt;
    logic [31:0]      w_data_r, w_data_nxt;
    logic [3:0]       w_strb_r, w_strb_nxt;
    logic             bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
    logic [1:0]       bresp_r, bresp_nxt, rresp_r, rresp_nxt;
    logic [31:0]      rdata_r, rdata_nxt;
    logic [3:0]       step_r, step_nxt;
    logic [PER_W-1:0] left_r, left_nxt;
    logic             rev_r, rev_nxt;
    logic [2:0]       cmd_r, cmd_nxt;
    logic [DO_N-1:0]  do_r, do_nxt;
    logic             tick;
    logic             wr_go;
    logic [2:0]       new_cmd;
    logic [3:0]       seq_next;
    logic             step_end;

    assr_tick #(.TICK_CYCLES(TICK_CYCLES)) u_tick (
        .aclk    (aclk),
        .aresetn (aresetn),
        .enable  (run_r),
        .tick    (tick)
    );

    // ----------------------------------------------------------------
    // Bus slave
    // ----------------------------------------------------------------
    // Address and data are latched independently so either may come first.
    assign wr_go = aw_hold_r && w_hold_r && !bvalid_r;

    always_comb begin
        aw_hold_nxt = aw_hold_r;
        aw_addr_nxt = aw_addr_r;
        w_hold_nxt  = w_hold_r;
        w_data_nxt  = w_data_r;
        w_strb_nxt  = w_strb_r;
        bvalid_nxt  = bvalid_r;
        bresp_nxt   = bresp_r;
        rvalid_nxt  = rvalid_r;
        rresp_nxt   = rresp_r;
        rdata_nxt   = rdata_r;
        mode_nxt    = mode_r;
        run_nxt     = run_r;
        do_sel_nxt  = do_sel_r;
        for (int i = 0; i < 5; i++) begin
            per_nxt[i] = per_r[i];
        end
        if (s_axi_awvalid && !aw_hold_r) begin
            aw_hold_nxt = 1'b1;
            aw_addr_nxt = s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_hold_r) begin
            w_hold_nxt = 1'b1;
            w_data_nxt = s_axi_wdata;
            w_strb_nxt = s_axi_wstrb;
        end
        if (bvalid_r && s_axi_bready) begin
            bvalid_nxt = 1'b0;
        end
        if (wr_go) begin
            aw_hold_nxt = 1'b0;
            w_hold_nxt  = 1'b0;
            bvalid_nxt  = 1'b1;
            bresp_nxt   = ASSR_RESP_OKAY;
            unique case (aw_addr_r)
                ASSR_OFS_CTRL:     if (w_strb_r[0]) run_nxt = w_data_r[ASSR_CTRL_RUN_BIT];
                ASSR_OFS_MODE:     if (w_strb_r[0]) mode_nxt = w_data_r[2:0];
                ASSR_OFS_JOG_PER:  per_nxt[0] = w_data_r[PER_W-1:0];
                ASSR_OFS_PRESET_SPEED_ONE_PER: per_nxt[1] = w_data_r[PER_W-1:0];
                ASSR_OFS_PRESET_SPEED_TWO_PER: per_nxt[2] = w_data_r[PER_W-1:0];
                ASSR_OFS_PRESET_SPEED_THREE_PER: per_nxt[3] = w_data_r[PER_W-1:0];
                ASSR_OFS_HALT_PER: per_nxt[4] = w_data_r[PER_W-1:0];
                ASSR_OFS_DO_SEL:   if (w_strb_r[0]) do_sel_nxt = w_data_r[DO_N-1:0];
                ASSR_OFS_STATUS:   bresp_nxt = ASSR_RESP_OKAY;
                default:           bresp_nxt = ASSR_RESP_SLVERR;
            endcase
        end
        if (rvalid_r && s_axi_rready) begin
            rvalid_nxt = 1'b0;
        end
        if (s_axi_arvalid && !rvalid_r) begin
            rvalid_nxt = 1'b1;
            rresp_nxt  = ASSR_RESP_OKAY;
            rdata_nxt  = '0;
            unique case (s_axi_araddr)
                ASSR_OFS_CTRL:     rdata_nxt[ASSR_CTRL_RUN_BIT] = run_r;
                ASSR_OFS_MODE:     rdata_nxt[2:0] = mode_r;
                ASSR_OFS_JOG_PER:  rdata_nxt[PER_W-1:0] = per_r[0];
                ASSR_OFS_PRESET_SPEED_ONE_PER: rdata_nxt[PER_W-1:0] = per_r[1];
                ASSR_OFS_PRESET_SPEED_TWO_PER: rdata_nxt[PER_W-1:0] = per_r[2];
                ASSR_OFS_PRESET_SPEED_THREE_PER: rdata_nxt[PER_W-1:0] = per_r[3];
                ASSR_OFS_HALT_PER: rdata_nxt[PER_W-1:0] = per_r[4];
                ASSR_OFS_STATUS:   rdata_nxt[11:0] = {rev_r, cmd_r, step_r, 3'b000, run_r};
                ASSR_OFS_DO_SEL:   rdata_nxt[DO_N-1:0] = do_sel_r;
                default:           rresp_nxt = ASSR_RESP_SLVERR;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Step sequencer
    // ----------------------------------------------------------------
    // Successor step for the selected mode.
    always_comb begin
        seq_next = step_r + 4'h1;
        if (step_r == ASSR_STEP_FIFTH && !(mode_r inside {ASSR_MODE_REVERSE, ASSR_MODE_MAIN_REV})) begin
            seq_next = ASSR_STEP_FIRST;
        end
        if (step_r == ASSR_STEP_FIFTH && mode_r == ASSR_MODE_MAIN_LOOP2) begin
            seq_next = ASSR_STEP_SECOND;
        end
        if (step_r == ASSR_STEP_TENTH) begin
            seq_next = ASSR_STEP_FIRST;
        end
    end

    always_comb begin
        unique case (seq_next)
            4'h1, 4'h6: new_cmd = ASSR_CMD_JOG;
            4'h2, 4'h7: new_cmd = ASSR_CMD_PRESET_SPEED_ONE;
            4'h3, 4'h8: new_cmd = ASSR_CMD_PRESET_SPEED_TWO;
            4'h4, 4'h9: new_cmd = ASSR_CMD_PRESET_SPEED_THREE;
            default: begin
                new_cmd = (mode_r inside {ASSR_MODE_MAIN, ASSR_MODE_MAIN_REV, ASSR_MODE_MAIN_LOOP2}) ?
                          ASSR_CMD_MAIN : ASSR_CMD_STOP;
            end
        endcase
    end

    assign step_end = (step_r == ASSR_STEP_IDLE) || (tick && left_r <= PER_W'(1));

    always_comb begin
        step_nxt = step_r;
        left_nxt = left_r;
        rev_nxt  = rev_r;
        cmd_nxt  = cmd_r;
        if (!run_r) begin
            step_nxt = ASSR_STEP_IDLE;
            rev_nxt  = 1'b0;
            cmd_nxt  = ASSR_CMD_STOP;
        end else if (step_end) begin
            step_nxt = seq_next;
            cmd_nxt  = new_cmd;
            unique case (new_cmd)
                ASSR_CMD_JOG:  left_nxt = per_r[0];
                ASSR_CMD_PRESET_SPEED_ONE: left_nxt = per_r[1];
                ASSR_CMD_PRESET_SPEED_TWO: left_nxt = per_r[2];
                ASSR_CMD_PRESET_SPEED_THREE: left_nxt = per_r[3];
                default:       left_nxt = per_r[4];
            endcase
            if (seq_next == ASSR_STEP_FIFTH + 4'h1) begin
                rev_nxt = 1'b1;
            end else if (seq_next == ASSR_STEP_FIRST) begin
                rev_nxt = 1'b0;
            end
        end else if (tick) begin
            left_nxt = left_r - PER_W'(1);
        end
    end

    always_comb begin
        for (int i = 0; i < DO_N; i++) begin
            do_nxt[i] = run_r && do_sel_r[i];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            run_r     <= 1'b0;
            mode_r    <= ASSR_MODE_RST;
            for (int i = 0; i < 5; i++) begin
                per_r[i] <= ASSR_PER_RST;
            end
            do_sel_r  <= '0;
            aw_hold_r <= 1'b0;
            aw_addr_r <= '0;
            w_hold_r  <= 1'b0;
            w_data_r  <= '0;
            w_strb_r  <= '0;
            bvalid_r  <= 1'b0;
            bresp_r   <= ASSR_RESP_OKAY;
            rvalid_r  <= 1'b0;
            rresp_r   <= ASSR_RESP_OKAY;
            rdata_r   <= '0;
            step_r    <= ASSR_STEP_IDLE;
            left_r    <= '0;
            rev_r     <= 1'b0;
            cmd_r     <= ASSR_CMD_STOP;
            do_r      <= '0;
        end else begin
            run_r     <= run_nxt;
            mode_r    <= mode_nxt;
            per_r     <= per_nxt;
            do_sel_r  <= do_sel_nxt;
            aw_hold_r <= aw_hold_nxt;
            aw_addr_r <= aw_addr_nxt;
            w_hold_r  <= w_hold_nxt;
            w_data_r  <= w_data_nxt;
            w_strb_r  <= w_strb_nxt;
            bvalid_r  <= bvalid_nxt;
            bresp_r   <= bresp_nxt;
            rvalid_r  <= rvalid_nxt;
            rresp_r   <= rresp_nxt;
            rdata_r   <= rdata_nxt;
            step_r    <= step_nxt;
            left_r    <= left_nxt;
            rev_r     <= rev_nxt;
            cmd_r     <= cmd_nxt;
            do_r      <= do_nxt;
        end
    end

    // Ready is the inverse of a holding flop, so it stays registered.
    assign s_axi_awready    = !aw_hold_r;
    assign s_axi_wready     = !w_hold_r;
    assign s_axi_bvalid     = bvalid_r;
    assign s_axi_bresp      = bresp_r;
    assign s_axi_arready    = !rvalid_r;
    assign s_axi_rvalid     = rvalid_r;
    assign s_axi_rresp      = rresp_r;
    assign s_axi_rdata      = rdata_r;
    assign speed_cmd        = cmd_r;
    assign reverse_dir      = rev_r;
    assign step_num         = step_r;
    assign digital_output_n = do_r;
endmodule : assr_top
`default_nettype wire

// ---- assr_pkg.sv ----
// Package of constants and types for the automatic multi-step speed sequencer.
`default_nettype none
package assr_pkg;
    // ----------------------------------------------------------------
    // Register byte offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] ASSR_OFS_CTRL     = 8'h00;
    localparam logic [7:0] ASSR_OFS_MODE     = 8'h04;
    localparam logic [7:0] ASSR_OFS_JOG_PER  = 8'h08;
    localparam logic [7:0] ASSR_OFS_PRESET_SPEED_ONE_PER = 8'h0C;
    localparam logic [7:0] ASSR_OFS_PRESET_SPEED_TWO_PER = 8'h10;
    localparam logic [7:0] ASSR_OFS_PRESET_SPEED_THREE_PER = 8'h14;
    localparam logic [7:0] ASSR_OFS_HALT_PER = 8'h18;
    localparam logic [7:0] ASSR_OFS_STATUS   = 8'h1C;
    localparam logic [7:0] ASSR_OFS_DO_SEL   = 8'h20;
    // ----------------------------------------------------------------
    // Field layout and reset values
    // ----------------------------------------------------------------
    localparam int         ASSR_CTRL_RUN_BIT = 0;
    localparam int         ASSR_PER_W        = 16;
    localparam int         ASSR_DO_N         = 2;
    localparam logic [2:0] ASSR_MODE_RST     = 3'h2;
    localparam logic [15:0] ASSR_PER_RST     = 16'h000A;
    localparam logic [1:0] ASSR_RESP_OKAY    = 2'b00;
    localparam logic [1:0] ASSR_RESP_SLVERR  = 2'b10;
    // ----------------------------------------------------------------
    // Step sequence modes
    // ----------------------------------------------------------------
    localparam logic [2:0] ASSR_MODE_REPEAT     = 3'h2;
    localparam logic [2:0] ASSR_MODE_REVERSE    = 3'h3;
    localparam logic [2:0] ASSR_MODE_MAIN       = 3'h4;
    localparam logic [2:0] ASSR_MODE_MAIN_REV   = 3'h5;
    localparam logic [2:0] ASSR_MODE_MAIN_LOOP2 = 3'h6;
    // ----------------------------------------------------------------
    // Step numbering and speed commands
    // ----------------------------------------------------------------
    localparam logic [3:0] ASSR_STEP_FIRST  = 4'h1;
    localparam logic [3:0] ASSR_STEP_SECOND = 4'h2;
    localparam logic [3:0] ASSR_STEP_FIFTH  = 4'h5;
    localparam logic [3:0] ASSR_STEP_TENTH  = 4'hA;
    localparam logic [3:0] ASSR_STEP_IDLE   = 4'h0;
    typedef enum logic [2:0] {
        ASSR_CMD_STOP  = 3'h0,
        ASSR_CMD_JOG   = 3'h1,
        ASSR_CMD_PRESET_SPEED_ONE  = 3'h2,
        ASSR_CMD_PRESET_SPEED_TWO  = 3'h3,
        ASSR_CMD_PRESET_SPEED_THREE  = 3'h4,
        ASSR_CMD_MAIN  = 3'h5
    } assr_cmd_t;
    // ----------------------------------------------------------------
    // Time base: one period unit is 100 ms at 20 MHz.
    // ----------------------------------------------------------------
    localparam int ASSR_CLK_HZ      = 20000000;
    localparam int ASSR_TICK_MS     = 100;
    localparam int ASSR_TICK_CYCLES = ASSR_CLK_HZ / 1000 * ASSR_TICK_MS;
endpackage : assr_pkg
`default_nettype wire

// ---- assr_tick.sv ----
// Fixed time base producing one pulse per period unit.
`default_nettype none
module assr_tick #(
    parameter int TICK_CYCLES = assr_pkg::ASSR_TICK_CYCLES
) (
    // Clock and reset
    input  wire logic aclk,
    input  wire logic aresetn,
    // Control
    input  wire logic enable,
    output var  logic tick
);
    import assr_pkg::*;

    localparam int CW = $clog2(TICK_CYCLES + 1);

    logic [CW-1:0] cnt_r;
    logic [CW-1:0] cnt_nxt;
    logic          tick_r;
    logic          tick_nxt;

    always_comb begin
        cnt_nxt  = cnt_r;
        tick_nxt = 1'b0;
        if (!enable) begin
            cnt_nxt = '0;
        end else if (cnt_r == CW'(TICK_CYCLES - 1)) begin
            cnt_nxt  = '0;
            tick_nxt = 1'b1;
        end else begin
            cnt_nxt = cnt_r + CW'(1);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_r  <= '0;
            tick_r <= 1'b0;
        end else begin
            cnt_r  <= cnt_nxt;
            tick_r <= tick_nxt;
        end
    end

    assign tick = tick_r;
endmodule : assr_tick
`default_nettype wire

// ---- assr_top_sva.sv ----
// Checker for step order, step commands, auto-run outputs and bus holds.
`default_nettype none
module assr_sva_chk #(
    parameter int DO_N = 2
) (
    // Clock and reset
    input wire logic            aclk,
    input wire logic            aresetn,
    // Bus handshakes
    input wire logic            s_axi_arvalid,
    input wire logic            s_axi_arready,
    input wire logic            s_axi_rvalid,
    input wire logic            s_axi_rready,
    input wire logic [31:0]     s_axi_rdata,
    input wire logic            s_axi_bvalid,
    input wire logic            s_axi_bready,
    input wire logic [1:0]      s_axi_bresp,
    // Sequencer outputs
    input wire logic [2:0]      speed_cmd,
    input wire logic            reverse_dir,
    input wire logic [3:0]      step_num,
    input wire logic [DO_N-1:0] digital_output_n
);
    import assr_pkg::*;
    // ----------------------------------------------------------------
    // Properties
    // ----------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_fwd_cmds: assert property (step_num inside {[4'h1:4'h4]} |-> speed_cmd == step_num[2:0])
        else $error("forward step command wrong");
    a_rev_cmds: assert property (step_num inside {[4'h6:4'h9]} |-> speed_cmd == 3'(step_num - 4'h5))
        else $error("reverse step command wrong");
    a_halt_cmd: assert property (step_num inside {4'h5, 4'hA} |-> speed_cmd inside {ASSR_CMD_STOP, ASSR_CMD_MAIN})
        else $error("halt step command wrong");
    a_dir_by_step: assert property (step_num != 4'h0 |-> reverse_dir == (step_num > 4'h5))
        else $error("direction does not match step");
    a_step_order: assert property ($changed(step_num) && step_num != 4'h0 |->
        ($past(step_num) == 4'h5 ? step_num inside {4'h1, 4'h2, 4'h6}
         : step_num == (($past(step_num) == 4'hA) ? 4'h1 : $past(step_num) + 4'h1)))
        else $error("step order broken");
    a_step_hold: assert property ($changed(step_num) && step_num != 4'h0 |=>
        ($stable(step_num) || step_num == 4'h0)[*3])
        else $error("step shorter than one tick period");
    a_do_idle: assert property ((step_num == 4'h0)[*3] |-> digital_output_n == '0)
        else $error("auto-run output set while idle");
    a_rd_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
endmodule : assr_sva_chk
bind assr_top assr_sva_chk #(.DO_N(DO_N)) chk_u (.aclk(aclk), .aresetn(aresetn),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .speed_cmd(speed_cmd),
    .reverse_dir(reverse_dir), .step_num(step_num), .digital_output_n(digital_output_n));
`default_nettype wire

// ---- assr_drive_model.sv ----
// Drive-side model that times how long each commanded step lasts.
`default_nettype none
module assr_drive_model (
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // Step number from the sequencer
    input  wire logic [3:0]  step_num,
    // Length in cycles of the last finished step
    output var  logic [15:0] seg_len
);
    logic [3:0]  prev_r;
    logic [15:0] cnt_r;
    // The drive accepts every command at once; a real one would ramp, which the timing ignores.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            prev_r  <= 4'h0;
            cnt_r   <= 16'h0000;
            seg_len <= 16'h0000;
        end else if (step_num != prev_r) begin
            prev_r  <= step_num;
            cnt_r   <= 16'h0001;
            seg_len <= cnt_r;
        end else begin
            cnt_r <= cnt_r + 16'h0001;
        end
    end
endmodule : assr_drive_model
`default_nettype wire

// ---- assr_top_bench.sv ----
// Self-checking bench: register access and step patterns of every mode.
`default_nettype none
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin fail_count++; \
    $display("wrong value %s expected %0h seen %0h", nm, e, g); end end
module assr_top_bench;
    timeunit 1ns;
    timeprecision 1ns;
    import assr_pkg::*;
    localparam int TC = 4;
    logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic        awready, wready, bvalid, arready, rvalid, reverse_dir;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, rd;
    logic [1:0]  bresp, rresp, dout, rsp;
    logic [2:0]  speed_cmd, md;
    logic [3:0]  step_num, exp_s, last_s;
    logic [15:0] seg_len;
    logic [15:0] per [5];
    int          fail_count, total_checks;
    assr_top #(.TICK_CYCLES(TC)) dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .speed_cmd(speed_cmd), .reverse_dir(reverse_dir), .step_num(step_num), .digital_output_n(dout));
    assr_drive_model drv_u (.aclk(aclk), .aresetn(aresetn), .step_num(step_num), .seg_len(seg_len));
    initial begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end
    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic close_out();
        if (fail_count == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : close_out
    task automatic bound(input int n, input int lim);
        if (n >= lim) begin
            fail_count++;
            close_out();
        end
    endtask : bound
    // Ready is raised late on purpose so that the slave must hold its answer.
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        @(posedge aclk);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        for (n = 0; n < 64; n++) begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid && bready) break;
            if (n == 2) bready <= 1'b1;
        end
        r = bresp;
        bready <= 1'b0;
        bound(n, 64);
    endtask : wr
    task automatic rdr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        for (n = 0; n < 64; n++) begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid && rready) break;
            if (n == 2) rready <= 1'b1;
        end
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        bound(n, 64);
    endtask : rdr
    task automatic wait_step(input logic [3:0] s);
        int n;
        for (n = 0; n < 400; n++) begin
            @(negedge aclk);
            if (step_num !== s) break;
        end
        bound(n, 400);
    endtask : wait_step
    function automatic logic [3:0] nxt(input logic [2:0] m, input logic [3:0] s);
        if (s == ASSR_STEP_TENTH) return ASSR_STEP_FIRST;
        if (s != ASSR_STEP_FIFTH) return s + 4'h1;
        if (m == ASSR_MODE_MAIN_LOOP2) return ASSR_STEP_SECOND;
        return (m == ASSR_MODE_REVERSE || m == ASSR_MODE_MAIN_REV) ? 4'h6 : ASSR_STEP_FIRST;
    endfunction : nxt
    function automatic logic [2:0] exp_cmd(input logic [2:0] m, input logic [3:0] s);
        if (s == 4'h5 || s == 4'hA) return (m inside {[3'h4:3'h6]}) ? ASSR_CMD_MAIN : ASSR_CMD_STOP;
        return 3'((s > 4'h5) ? s - 4'h5 : s);
    endfunction : exp_cmd
    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
        {awaddr, araddr, wdata} = 48'h0;
        per = '{16'h0001, 16'h0002, 16'h0003, 16'h0001, 16'h0002};
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        for (int i = 0; i < 9; i++) begin
            rdr(8'(4 * i), rd, rsp);
            `CHK("reset value", (i == 1) ? 32'(ASSR_MODE_RST) : (i inside {[2:6]}) ? 32'(ASSR_PER_RST) : 32'h0, rd)
        end
        rdr(8'h40, rd, rsp);
        `CHK("unmapped read", ASSR_RESP_SLVERR, rsp)
        wr(8'h40, 32'h1, rsp);
        `CHK("unmapped write", ASSR_RESP_SLVERR, rsp)
        wr(ASSR_OFS_STATUS, 32'hFFFF, rsp);
        rdr(ASSR_OFS_STATUS, rd, rsp);
        `CHK("status kept", 32'h0, rd)
        for (int i = 0; i < 5; i++) wr(ASSR_OFS_JOG_PER + 8'(4 * i), 32'(per[i]), rsp);
        rdr(ASSR_OFS_PRESET_SPEED_TWO_PER, rd, rsp);
        `CHK("period kept", 32'(per[2]), rd)
        for (int m = 2; m < 8; m++) begin
            md = 3'(m);
            wr(ASSR_OFS_MODE, 32'(md), rsp);
            wr(ASSR_OFS_DO_SEL, 32'(md[1:0]), rsp);
            wr(ASSR_OFS_CTRL, 32'h1, rsp);
            wait_step(ASSR_STEP_IDLE);
            exp_s = ASSR_STEP_FIRST;
            for (int k = 0; k < 12; k++) begin
                `CHK("step", exp_s, step_num)
                `CHK("command", exp_cmd(md, exp_s), speed_cmd)
                `CHK("direction", exp_s > 4'h5, reverse_dir)
                `CHK("auto run out", md[1:0], dout)
                @(negedge aclk);
                if (k > 0) `CHK("step length", 16'(per[(int'(last_s) - 1) % 5] * TC), seg_len)
                wait_step(exp_s);
                last_s = exp_s;
                exp_s = nxt(md, exp_s);
            end
            wr(ASSR_OFS_CTRL, 32'h0, rsp);
            repeat (4) @(negedge aclk);
            `CHK("idle step", ASSR_STEP_IDLE, step_num)
            `CHK("idle out", 2'h0, dout)
        end
        close_out();
    end
endmodule : assr_top_bench
`default_nettype wire
